// >>> shared/rsp_pkg.sv
// Overview of operation
// R1 - packet format 3 selects asynchronous serial mode
// R2 - asynchronous mode bypasses packet engine and FIFOs
// R3 - asynchronous mode: no whitening, interleave, FEC, Manchester
// R4 - transmit on pin 0, receive on selected pin
// R5 - modulator samples transmit input at 8x rate
// R6 - host keeps bit period error under one eighth
// R7 - packet format 1 selects synchronous two-wire mode
// R8 - device drives bit clock; host follows it
// R9 - pin 0 becomes input while transmitting
// R10 - preamble and sync only when sync mode enables
// R11 - host disables packet features without sync handling
// R12 - host handles preamble and sync when disabled
// R13 - no address filtering in synchronous mode
// R14 - device adds preamble/sync; host moves payload only
// R15 - select code exposes pin 0 output enable low
// R16 - clock once per bit; data stable at rise
package rsp_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_PIN_TWO_CFG = 8'h00;
   localparam logic [7:0] IDX_PIN_ONE_CFG = 8'h01;
   localparam logic [7:0] IDX_PIN_ZERO_CFG = 8'h02;
   localparam logic [7:0] IDX_SYNC_HI = 8'h04;
   localparam logic [7:0] IDX_SYNC_LO = 8'h05;
   localparam logic [7:0] IDX_PKT_CTRL0 = 8'h08;
   localparam logic [7:0] IDX_MODEM_CFG2 = 8'h10;
   localparam logic [7:0] IDX_SER_CTRL = 8'h20;
   localparam logic [7:0] IDX_RATE_DIV = 8'h21;
   localparam logic [7:0] IDX_SER_STATUS = 8'h22;
   localparam int unsigned ADDR_W = 12;
   // field layouts
   localparam int unsigned SEL_W = 6;
   localparam int unsigned FMT_W = 2;
   localparam int unsigned SMODE_W = 3;
   localparam int unsigned DIV_W = 16;
   localparam int unsigned CTRL_TX_BIT = 0;
   localparam int unsigned CTRL_RX_BIT = 1;
   localparam int unsigned STAT_SYNCED_BIT = 0;
   localparam int unsigned STAT_TXBUSY_BIT = 1;
   // packet format encodings
   localparam logic [FMT_W-1:0] FMT_NORMAL = 2'h0;
   localparam logic [FMT_W-1:0] FMT_SYNC = 2'h1;
   localparam logic [FMT_W-1:0] FMT_ASYNC = 2'h3;
   localparam logic [SMODE_W-1:0] SMODE_OFF = 3'h0;
   // pin select codes
   localparam logic [SEL_W-1:0] SEL_SER_CLK = 6'h08;
   localparam logic [SEL_W-1:0] SEL_SER_DATA = 6'h09;
   localparam logic [SEL_W-1:0] SEL_PIN0_OE_LOW = 6'h2D;
   localparam logic [SEL_W-1:0] SEL_HIGHZ = 6'h2E;
   // reset values
   localparam logic [SEL_W-1:0] PIN_CFG_RST = 6'h2E;
   // pin 0 wakes up on a clock-output code; that clock is not modelled, the pin drives 0
   localparam logic [SEL_W-1:0] PIN0_CFG_RST = 6'h3F;
   localparam logic [FMT_W-1:0] FMT_RST = 2'h0;
   localparam logic [SMODE_W-1:0] SMODE_RST = 3'h0;
   localparam logic [7:0] SYNC_BYTE_RST = 8'h00;
   localparam logic [DIV_W-1:0] DIV_RST = 16'h0018;
   // oversampling ratio and bit phases
   localparam int unsigned OS_RATIO = 8;
   localparam logic [2:0] PH_LAST = 3'h7;
   localparam logic [2:0] PH_MID = 3'h3;
   localparam logic [2:0] PH_RISE = 3'h4;
   localparam int unsigned SYNC_BITS = 16;
   typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_SYNC, TX_PAY} rsp_tx_state_t;
endpackage : rsp_pkg

// >>> hdl/rsp_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser; the first stage feeds only the second
module rsp_sync #(
   parameter int unsigned W = 1
) (
   input wire logic clk, // destination clock
   input wire logic rst_n, // async reset, active low
   input wire logic [W-1:0] d, // level from another domain
   output logic [W-1:0] q // synchronised level
);
   logic [W-1:0] meta_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : rsp_sync
`default_nettype wire

// >>> hdl/rsp_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
module rsp_serial_port
   import rsp_pkg::*;
#(
   parameter int unsigned PREAMBLE_BYTES = 4
) (
   input wire logic pclk, // bus clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [ADDR_W-1:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic lclk, // radio link clock
   input wire logic [2:0] gdo_in, // pin levels seen
   output logic [2:0] gdo_out, // pin drive levels
   output logic [2:0] gdo_oe, // pin output enables
   input wire logic rx_demod_bit, // demodulator bit
   output logic tx_mod_bit, // modulator bit
   output logic tx_mod_en, // modulator bit valid
   output logic fifo_bypass, // fifos not used
   output logic pkt_bypass, // packet engine bypassed
   output logic coding_bypass // line coding off
);
   localparam int unsigned PRE_BITS = PREAMBLE_BYTES * 8;
   localparam int unsigned CFG_W = 3 * SEL_W + FMT_W + SMODE_W + 16 + DIV_W + 2;

   if (PREAMBLE_BYTES < 1 || PREAMBLE_BYTES > 31) begin : g_bad_pre
      $error("PREAMBLE_BYTES must be 1 to 31");
   end

   function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
      logic [7:0] ix;
      ix = a[9:2];
      return (a[1:0] == 2'b00) && (a[ADDR_W-1:10] == '0) &&
         (ix inside {IDX_PIN_TWO_CFG, IDX_PIN_ONE_CFG, IDX_PIN_ZERO_CFG, IDX_SYNC_HI, IDX_SYNC_LO,
                     IDX_PKT_CTRL0, IDX_MODEM_CFG2, IDX_SER_CTRL, IDX_RATE_DIV, IDX_SER_STATUS});
   endfunction : addr_ok

   // {oe, level} for one pin from its select code
   function automatic logic [1:0] pin_drive(input logic [SEL_W-1:0] sel, input logic ck,
                                            input logic dat, input logic oen0);
      case (sel)
         SEL_SER_CLK: return {1'b1, ck};
         SEL_SER_DATA: return {1'b1, dat};
         SEL_PIN0_OE_LOW: return {1'b1, oen0};
         SEL_HIGHZ: return 2'b00;
         default: return 2'b10;
      endcase
   endfunction : pin_drive

   // ---------------- bus domain ----------------
   logic [SEL_W-1:0] sel_q [3];
   logic [FMT_W-1:0] fmt_q;
   logic [SMODE_W-1:0] smode_q;
   logic [7:0] sync_hi_q;
   logic [7:0] sync_lo_q;
   logic [DIV_W-1:0] div_q;
   logic tx_en_q;
   logic rx_en_q;
   logic [31:0] prdata_q;
   logic [31:0] rd_val;
   logic [1:0] stat_p;
   logic fifo_byp_q;
   logic pkt_byp_q;
   logic cod_byp_q;
   logic wr_en;
   logic [7:0] wr_ix;

   assign wr_en = psel && penable && pwrite && addr_ok(paddr);
   assign wr_ix = paddr[9:2];
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok(paddr);
   assign prdata = prdata_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_q[0] <= PIN0_CFG_RST;
         sel_q[1] <= PIN_CFG_RST;
         sel_q[2] <= PIN_CFG_RST;
         fmt_q <= FMT_RST;
         smode_q <= SMODE_RST;
         sync_hi_q <= SYNC_BYTE_RST;
         sync_lo_q <= SYNC_BYTE_RST;
         div_q <= DIV_RST;
         tx_en_q <= 1'b0;
         rx_en_q <= 1'b0;
      end else if (wr_en) begin
         unique case (wr_ix)
            IDX_PIN_ZERO_CFG: sel_q[0] <= pwdata[SEL_W-1:0];
            IDX_PIN_ONE_CFG: sel_q[1] <= pwdata[SEL_W-1:0];
            IDX_PIN_TWO_CFG: sel_q[2] <= pwdata[SEL_W-1:0];
            IDX_PKT_CTRL0: fmt_q <= pwdata[FMT_W-1:0];
            IDX_MODEM_CFG2: smode_q <= pwdata[SMODE_W-1:0];
            IDX_SYNC_HI: sync_hi_q <= pwdata[7:0];
            IDX_SYNC_LO: sync_lo_q <= pwdata[7:0];
            IDX_RATE_DIV: div_q <= pwdata[DIV_W-1:0];
            IDX_SER_CTRL: begin
               tx_en_q <= pwdata[CTRL_TX_BIT];
               rx_en_q <= pwdata[CTRL_RX_BIT];
            end
            default: ;
         endcase
      end
   end

   always_comb begin
      rd_val = '0;
      case (paddr[9:2])
         IDX_PIN_ZERO_CFG: rd_val[SEL_W-1:0] = sel_q[0];
         IDX_PIN_ONE_CFG: rd_val[SEL_W-1:0] = sel_q[1];
         IDX_PIN_TWO_CFG: rd_val[SEL_W-1:0] = sel_q[2];
         IDX_PKT_CTRL0: rd_val[FMT_W-1:0] = fmt_q;
         IDX_MODEM_CFG2: rd_val[SMODE_W-1:0] = smode_q;
         IDX_SYNC_HI: rd_val[7:0] = sync_hi_q;
         IDX_SYNC_LO: rd_val[7:0] = sync_lo_q;
         IDX_RATE_DIV: rd_val[DIV_W-1:0] = div_q;
         IDX_SER_CTRL: begin
            rd_val[CTRL_TX_BIT] = tx_en_q;
            rd_val[CTRL_RX_BIT] = rx_en_q;
         end
         IDX_SER_STATUS: rd_val[1:0] = stat_p;
         default: rd_val = '0;
      endcase
   end

   // read data is captured in the setup cycle so the access cycle needs no wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata_q <= addr_ok(paddr) ? rd_val : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_byp_q <= 1'b0;
         pkt_byp_q <= 1'b0;
         cod_byp_q <= 1'b0;
      end else begin
         // R1 async mode select
         // R2 bypass fifo and packet engine
         fifo_byp_q <= (fmt_q == FMT_ASYNC) || (fmt_q == FMT_SYNC);
         pkt_byp_q <= (fmt_q == FMT_ASYNC) || (fmt_q == FMT_SYNC && smode_q == SMODE_OFF);
         // R3 no line coding
         cod_byp_q <= (fmt_q == FMT_ASYNC);
      end
   end
   assign fifo_bypass = fifo_byp_q;
   assign pkt_bypass = pkt_byp_q;
   assign coding_bypass = cod_byp_q;

   // ---------------- crossing ----------------
   // config is carried as quasi-static levels: change it only with tx and rx disabled
   logic lrst_n;
   logic [CFG_W-1:0] cfg_l;
   logic pin0_s;
   logic [1:0] stat_l;
   logic [SEL_W-1:0] sel_l [3];
   logic [FMT_W-1:0] fmt_l;
   logic [SMODE_W-1:0] smode_l;
   logic [15:0] syncw_l;
   logic [DIV_W-1:0] div_l;
   logic txen_l;
   logic rxen_l;

   rsp_sync #(.W(1)) u_lrst (.clk(lclk), .rst_n(presetn), .d(1'b1), .q(lrst_n));
   rsp_sync #(.W(CFG_W)) u_cfg (
      .clk(lclk), .rst_n(lrst_n),
      .d({sel_q[2], sel_q[1], sel_q[0], fmt_q, smode_q, sync_hi_q, sync_lo_q, div_q, tx_en_q, rx_en_q}),
      .q(cfg_l));
   rsp_sync #(.W(1)) u_pin0 (.clk(lclk), .rst_n(lrst_n), .d(gdo_in[0]), .q(pin0_s));
   rsp_sync #(.W(2)) u_stat (.clk(pclk), .rst_n(presetn), .d(stat_l), .q(stat_p));
   assign {sel_l[2], sel_l[1], sel_l[0], fmt_l, smode_l, syncw_l, div_l, txen_l, rxen_l} = cfg_l;

   // ---------------- link domain ----------------
   logic async_l;
   logic sync_l;
   logic ser_l;
   logic tx_act;
   logic rx_act;
   logic go;
   assign async_l = (fmt_l == FMT_ASYNC);
   // R7 sync mode select
   assign sync_l = (fmt_l == FMT_SYNC);
   assign ser_l = async_l || sync_l;
   assign tx_act = ser_l && txen_l;
   assign rx_act = ser_l && rxen_l && !txen_l;
   assign go = sync_l && tx_act;

   logic [DIV_W-1:0] dcnt_q;
   logic [2:0] ph_q;
   logic tick;
   logic mid;
   logic bit_end;
   // compare with >= so lowering the divider while running cannot strand the counter
   assign tick = (dcnt_q >= div_l);
   assign mid = tick && (ph_q == PH_MID);
   assign bit_end = tick && (ph_q == PH_LAST);

   // R5 eight samples per bit
   always_ff @(posedge lclk or negedge lrst_n) begin
      if (!lrst_n) begin
         dcnt_q <= '0;
         ph_q <= 3'h0;
      end else if (!ser_l) begin
         dcnt_q <= '0;
         ph_q <= 3'h0;
      end else if (tick) begin
         dcnt_q <= '0;
         ph_q <= ph_q + 3'h1;
      end else begin
         dcnt_q <= dcnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
      end
   end

   rsp_tx_state_t tx_st_q;
   logic [7:0] tx_cnt_q;
   logic pay_bit_q;
   logic tx_mod_q;
   logic tx_mod_en_q;

   always_ff @(posedge lclk or negedge lrst_n) begin
      if (!lrst_n) begin
         tx_st_q <= TX_IDLE;
         tx_cnt_q <= 8'h00;
      end else if (!go) begin
         tx_st_q <= TX_IDLE;
         tx_cnt_q <= 8'h00;
      end else if (bit_end) begin
         unique case (tx_st_q)
            // R10 framing only when enabled
            TX_IDLE: tx_st_q <= (smode_l == SMODE_OFF) ? TX_PAY : TX_PRE;
            // R14 device inserts preamble and sync
            TX_PRE: begin
               tx_cnt_q <= (tx_cnt_q == 8'(PRE_BITS - 1)) ? 8'h00 : tx_cnt_q + 8'h01;
               if (tx_cnt_q == 8'(PRE_BITS - 1)) tx_st_q <= TX_SYNC;
            end
            TX_SYNC: begin
               tx_cnt_q <= (tx_cnt_q == 8'(SYNC_BITS - 1)) ? 8'h00 : tx_cnt_q + 8'h01;
               if (tx_cnt_q == 8'(SYNC_BITS - 1)) tx_st_q <= TX_PAY;
            end
            TX_PAY: tx_st_q <= TX_PAY;
         endcase
      end
   end

   // R9 sample host data at clock rise
   always_ff @(posedge lclk or negedge lrst_n) begin
      if (!lrst_n) begin
         pay_bit_q <= 1'b0;
      end else if (go && tx_st_q == TX_PAY && mid) begin
         pay_bit_q <= pin0_s;
      end
   end

   always_ff @(posedge lclk or negedge lrst_n) begin
      if (!lrst_n) begin
         tx_mod_q <= 1'b0;
         tx_mod_en_q <= 1'b0;
      end else if (async_l && tx_act) begin
         // R5 raw level, oversampled
         tx_mod_en_q <= 1'b1;
         if (tick) tx_mod_q <= pin0_s;
      end else if (go) begin
         tx_mod_en_q <= (tx_st_q != TX_IDLE);
         if (bit_end) begin
            unique case (tx_st_q)
               TX_IDLE: tx_mod_q <= 1'b0;
               TX_PRE: tx_mod_q <= ~tx_cnt_q[0];
               TX_SYNC: tx_mod_q <= syncw_l[4'(SYNC_BITS - 1) - tx_cnt_q[3:0]];
               TX_PAY: tx_mod_q <= pay_bit_q;
            endcase
         end
      end else begin
         tx_mod_q <= 1'b0;
         tx_mod_en_q <= 1'b0;
      end
   end
   assign tx_mod_bit = tx_mod_q;
   assign tx_mod_en = tx_mod_en_q;

   logic [15:0] rx_sr_q;
   logic rx_synced_q;
   logic rx_out_q;
   logic rx_dm_q;
   logic [15:0] rx_next;
   assign rx_next = {rx_sr_q[14:0], rx_demod_bit};

   always_ff @(posedge lclk or negedge lrst_n) begin
      if (!lrst_n) begin
         rx_sr_q <= 16'h0000;
         rx_synced_q <= 1'b0;
      end else if (!(sync_l && rx_act)) begin
         rx_sr_q <= 16'h0000;
         rx_synced_q <= 1'b0;
      end else if (mid) begin
         rx_sr_q <= rx_next;
         // R10 hunt sync word only when enabled
         // R13 no address compare on payload
         if (smode_l == SMODE_OFF || rx_next == syncw_l) rx_synced_q <= 1'b1;
      end
   end

   // R16 data changes at clock fall
   always_ff @(posedge lclk or negedge lrst_n) begin
      if (!lrst_n) begin
         rx_out_q <= 1'b0;
         rx_dm_q <= 1'b0;
      end else begin
         rx_dm_q <= rx_demod_bit;
         if (bit_end && rx_synced_q) rx_out_q <= rx_sr_q[0];
      end
   end

   logic clk_run;
   logic bclk_q;
   logic [2:0] ph_d;
   assign ph_d = tick ? ph_q + 3'h1 : ph_q;
   // R14 clock runs for payload only
   assign clk_run = (sync_l && rx_act && rx_synced_q) || (go && tx_st_q == TX_PAY);
   // R8 one clock period per bit
   always_ff @(posedge lclk or negedge lrst_n) begin
      if (!lrst_n) begin
         bclk_q <= 1'b0;
      end else begin
         bclk_q <= clk_run && ph_d[2];
      end
   end

   logic ser_dat;
   logic oen0;
   // R4 receive data source per mode
   assign ser_dat = async_l ? (rx_act && rx_dm_q) : (rx_act && rx_out_q);
   // R15 pin 0 enable exposed, low means input
   assign oen0 = !tx_act && (sel_l[0] != SEL_HIGHZ);

   for (genvar i = 0; i < 3; i++) begin : g_pin
      logic [1:0] drv_q;
      always_ff @(posedge lclk or negedge lrst_n) begin
         if (!lrst_n) begin
            drv_q <= 2'b00;
         end else begin
            drv_q <= pin_drive(sel_l[i], bclk_q, ser_dat, oen0);
            // R9 pin 0 released while transmitting
            if (i == 0 && tx_act) drv_q <= 2'b00;
         end
      end
      assign gdo_oe[i] = drv_q[1];
      assign gdo_out[i] = drv_q[0];
   end

   assign stat_l[STAT_SYNCED_BIT] = rx_synced_q;
   assign stat_l[STAT_TXBUSY_BIT] = tx_mod_en_q;

   // ---------------- checks ----------------
   property p_async_entry;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && wr_ix == IDX_PKT_CTRL0 && pwdata[FMT_W-1:0] == FMT_ASYNC) |=> ##1 (coding_bypass && fifo_bypass);
   endproperty
   a_async_entry: assert property (p_async_entry) else $error("async format did not bypass"); // R1
   property p_async_pkt;
      @(posedge pclk) disable iff (!presetn)
      (fmt_q == FMT_ASYNC) |=> (pkt_bypass && fifo_bypass);
   endproperty
   a_async_pkt: assert property (p_async_pkt) else $error("packet engine active in async"); // R2
   property p_coding;
      @(posedge pclk) disable iff (!presetn)
      coding_bypass |-> $past(fmt_q) == FMT_ASYNC;
   endproperty
   a_coding: assert property (p_coding) else $error("coding bypass without async"); // R3
   property p_rx_route;
      @(posedge lclk) disable iff (!lrst_n)
      (async_l && rx_act && sel_l[1] == SEL_SER_DATA)[*3] |-> gdo_out[1] == $past(rx_demod_bit, 2);
   endproperty
   a_rx_route: assert property (p_rx_route) else $error("async rx data not on pin"); // R4
   property p_os_sample;
      @(posedge lclk) disable iff (!lrst_n)
      (async_l && tx_act && tick) ##1 (async_l && tx_act) |-> tx_mod_bit == $past(pin0_s);
   endproperty
   a_os_sample: assert property (p_os_sample) else $error("tx input not sampled on tick"); // R5
   property p_sync_entry;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && wr_ix == IDX_PKT_CTRL0 && pwdata[FMT_W-1:0] == FMT_SYNC) |=> ##1 (fifo_bypass && !coding_bypass);
   endproperty
   a_sync_entry: assert property (p_sync_entry) else $error("sync format not entered"); // R7
   property p_bclk_rise;
      @(posedge lclk) disable iff (!lrst_n)
      $rose(bclk_q) |-> ph_q == PH_RISE;
   endproperty
   a_bclk_rise: assert property (p_bclk_rise) else $error("bit clock rose off phase"); // R8
   property p_pin0_in;
      @(posedge lclk) disable iff (!lrst_n)
      (sync_l && tx_act)[*2] |-> !gdo_oe[0];
   endproperty
   a_pin0_in: assert property (p_pin0_in) else $error("pin 0 driven during tx"); // R9
   property p_no_frame;
      @(posedge lclk) disable iff (!lrst_n)
      (tx_st_q == TX_IDLE && go && bit_end && smode_l == SMODE_OFF) |=> tx_st_q == TX_PAY;
   endproperty
   a_no_frame: assert property (p_no_frame) else $error("framing inserted while disabled"); // R10
   property p_quiet_clk;
      @(posedge lclk) disable iff (!lrst_n)
      (go && tx_st_q inside {TX_PRE, TX_SYNC} && !rx_act)[*2] |-> !bclk_q;
   endproperty
   a_quiet_clk: assert property (p_quiet_clk) else $error("clock ran during framing"); // R14
   property p_oe_low;
      @(posedge lclk) disable iff (!lrst_n)
      (sel_l[2] == SEL_PIN0_OE_LOW)[*2] |-> gdo_out[2] == gdo_oe[0];
   endproperty
   a_oe_low: assert property (p_oe_low) else $error("pin 0 enable not mirrored"); // R15
   property p_rx_edge;
      @(posedge lclk) disable iff (!lrst_n)
      (sync_l && $changed(rx_out_q)) |-> !bclk_q;
   endproperty
   a_rx_edge: assert property (p_rx_edge) else $error("rx data changed with clock high"); // R16
endmodule : rsp_serial_port
`default_nettype wire

// >>> sim/rsp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the pins: bit clock on pin 2, serial data on pin 1
module rsp_host_model (
   input wire logic clr, // restart bit counters
   input wire logic sync_mode, // follow the bit clock
   input wire logic async_level, // raw transmit level
   input wire logic [15:0] tx_word, // payload, msb first
   input wire logic [2:0] gdo_out, // device drive levels
   input wire logic [2:0] gdo_oe, // device enables
   output logic [2:0] gdo_in, // resolved pin levels
   output logic [15:0] rx_word, // last 16 bits seen
   output logic [7:0] rise_cnt // bit clock rises seen
);
   logic [3:0] idx_q;
   logic host_bit;
   assign host_bit = sync_mode ? tx_word[4'hF - idx_q] : async_level;
   assign gdo_in[0] = gdo_oe[0] ? gdo_out[0] : host_bit;
   // undriven pins 1 and 2 show the inverse so stale data never passes
   assign gdo_in[2:1] = (gdo_oe[2:1] & gdo_out[2:1]) | (~gdo_oe[2:1] & ~gdo_out[2:1]);
   // receive bit taken on the rise
   always @(posedge gdo_out[2] or posedge clr) begin
      if (clr) begin
         rise_cnt <= 8'h00;
         rx_word <= 16'h0000;
      end else begin
         rise_cnt <= rise_cnt + 8'h01;
         rx_word <= {rx_word[14:0], gdo_out[1]};
      end
   end
   // next bit presented on the fall
   always @(negedge gdo_out[2] or posedge clr) begin
      if (clr) begin
         idx_q <= 4'h0;
      end else begin
         idx_q <= rise_cnt[3:0];
      end
   end
endmodule : rsp_host_model
`default_nettype wire

// >>> sim/rsp_serial_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rsp_serial_port_tb_top
   import rsp_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, lclk, rx_demod_bit, clr, sync_mode, async_level;
   logic pready, pslverr, er, tx_mod_bit, tx_mod_en, fifo_bypass, pkt_bypass, coding_bypass;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] gdo_in, gdo_out, gdo_oe;
   logic [15:0] tx_word, rx_word;
   logic [7:0] rise_cnt;
   int fails, compares;
   initial pclk = 1'b0;
   always #50 pclk = ~pclk;
   // 125 ns, phase drifts against pclk
   initial lclk = 1'b0;
   always #62.5 lclk = ~lclk;
   rsp_serial_port #(.PREAMBLE_BYTES(1)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .lclk, .gdo_in, .gdo_out, .gdo_oe, .rx_demod_bit,
      .tx_mod_bit, .tx_mod_en, .fifo_bypass, .pkt_bypass, .coding_bypass);
   rsp_host_model host_u (.clr, .sync_mode, .async_level, .tx_word, .gdo_out, .gdo_oe, .gdo_in,
      .rx_word, .rise_cnt);
   task automatic tally_and_finish;
      if (fails == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic chkb(input string what, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %b seen %b", what, exp, got);
      end
   endtask : chkb
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      apb(1'b1, ADDR_W'({idx, 2'b00}), d);
   endtask : wr
   task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input string what);
      apb(1'b0, ADDR_W'({idx, 2'b00}), 32'h0000_0000);
      chk(what, exp, rd);
   endtask : rdc
   task automatic lc(input int n);
      repeat (n) @(posedge lclk);
   endtask : lc
   task automatic t_regs;
      chk("bypass", 32'h0000_0000, 32'({fifo_bypass, pkt_bypass, coding_bypass}));
      rdc(IDX_PIN_ZERO_CFG, 32'(PIN0_CFG_RST), "pin0 cfg");
      rdc(IDX_PIN_TWO_CFG, 32'(PIN_CFG_RST), "pin2 cfg");
      rdc(IDX_RATE_DIV, 32'(DIV_RST), "rate div");
      rdc(IDX_PKT_CTRL0, 32'(FMT_RST), "format");
      rdc(IDX_MODEM_CFG2, 32'(SMODE_RST), "sync mode");
      wr(IDX_SYNC_LO, 32'hFFFF_FF5A);
      rdc(IDX_SYNC_LO, 32'h0000_005A, "sync low");
      apb(1'b0, 12'h0C0, 32'h0000_0000);
      chk("unmapped data", 32'h0000_0000, rd);
      chkb("unmapped err", 1'b1, er);
      apb(1'b1, 12'h015, 32'h0000_0033);
      chkb("unaligned err", 1'b1, er);
      rdc(IDX_SYNC_LO, 32'h0000_005A, "sync low kept");
   endtask : t_regs
   task automatic t_async;
      wr(IDX_RATE_DIV, 32'h0000_0000);
      wr(IDX_PKT_CTRL0, 32'(FMT_ASYNC));
      wr(IDX_PIN_ONE_CFG, 32'(SEL_SER_DATA));
      wr(IDX_PIN_TWO_CFG, 32'(SEL_PIN0_OE_LOW));
      wr(IDX_SER_CTRL, 32'h0000_0001);
      lc(8);
      chk("bypass", 32'h0000_0007, 32'({fifo_bypass, pkt_bypass, coding_bypass}));
      chkb("pin0 oe", 1'b0, gdo_oe[0]);
      chkb("oe low view", 1'b0, gdo_out[2]);
      chkb("mod en", 1'b1, tx_mod_en);
      for (int i = 0; i < 6; i++) begin
         @(posedge lclk) async_level <= i[0] ^ i[1];
         // each level is held for 9 ticks, one tick longer than the 8-tick bit period
         lc(8);
         chkb("mod bit", i[0] ^ i[1], tx_mod_bit);
      end
      wr(IDX_SER_CTRL, 32'h0000_0002);
      for (int i = 0; i < 4; i++) begin
         @(posedge lclk) rx_demod_bit <= ~i[0];
         lc(6);
         chkb("rx pin", ~i[0], gdo_out[1]);
      end
      chkb("rx oe", 1'b1, gdo_oe[1]);
      wr(IDX_PIN_ZERO_CFG, 32'(SEL_SER_DATA));
      lc(6);
      chkb("oe low view", 1'b1, gdo_out[2]);
   endtask : t_async
   task automatic t_sync_rx;
      logic [15:0] pat;
      int n;
      pat = 16'hC5A3;
      wr(IDX_SER_CTRL, 32'h0000_0000);
      wr(IDX_PKT_CTRL0, 32'(FMT_SYNC));
      wr(IDX_MODEM_CFG2, 32'(SMODE_OFF));
      wr(IDX_PIN_TWO_CFG, 32'(SEL_SER_CLK));
      wr(IDX_RATE_DIV, 32'h0000_0001);
      clr <= 1'b1;
      @(posedge pclk) clr <= 1'b0;
      wr(IDX_SER_CTRL, 32'h0000_0002);
      chk("bypass", 32'h0000_0006, 32'({fifo_bypass, pkt_bypass, coding_bypass}));
      for (int r = 1; r <= 33; r++) begin
         n = 0;
         while (rise_cnt != r && n < 100) begin
            @(posedge lclk);
            n++;
         end
         if (r > 2) chk("bit period", 32'd15, 32'(n));
         @(posedge lclk) rx_demod_bit <= pat[15 - (r % 16)];
      end
      chk("rx word", 32'(pat), 32'(rx_word));
      rdc(IDX_SER_STATUS, 32'h0000_0001, "status");
   endtask : t_sync_rx
   task automatic t_sync_tx(input logic [2:0] sm, input int lo, input int hi);
      int n;
      logic bad;
      logic [15:0] got;
      wr(IDX_SER_CTRL, 32'h0000_0000);
      wr(IDX_RATE_DIV, 32'h0000_0000);
      wr(IDX_MODEM_CFG2, 32'(sm));
      wr(IDX_SYNC_HI, 32'h0000_00D3);
      wr(IDX_SYNC_LO, 32'h0000_0091);
      lc(20);
      chkb("clock idle", 1'b0, gdo_out[2]);
      clr <= 1'b1;
      sync_mode <= 1'b1;
      tx_word <= 16'hB4E1;
      @(posedge pclk) clr <= 1'b0;
      wr(IDX_SER_CTRL, 32'h0000_0001);
      // pin 0 was driven before tx; give the enable three link cycles to cross
      lc(3);
      n = 0;
      bad = 1'b0;
      while (gdo_out[2] !== 1'b1 && n < 600) begin
         @(posedge lclk);
         n++;
         bad |= gdo_oe[0];
      end
      chkb("pin0 input", 1'b0, bad);
      chkb("clock start", 1'b1, n >= lo && n <= hi);
      chk("bypass", (sm == SMODE_OFF) ? 32'h0000_0006 : 32'h0000_0004, 32'({fifo_bypass, pkt_bypass, coding_bypass}));
      for (int r = 2; r <= 17; r++) begin
         n = 0;
         while (rise_cnt != r && n < 100) begin
            @(posedge lclk);
            n++;
         end
         got = {got[14:0], tx_mod_bit};
      end
      chk("payload", 32'(tx_word), 32'(got));
   endtask : t_sync_tx
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0000_0000;
      rx_demod_bit = 1'b0;
      clr = 1'b1;
      sync_mode = 1'b0;
      async_level = 1'b0;
      tx_word = 16'h0000;
      fails = 0;
      compares = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk) clr <= 1'b0;
      t_regs;
      t_async;
      t_sync_rx;
      // one idle bit, 8 preamble bits and 16 sync bits of 8 cycles precede the clock
      t_sync_tx(3'h2, 195, 225);
      t_sync_tx(SMODE_OFF, 5, 35);
      tally_and_finish;
   end
   initial begin
      #3_000_000;
      fails++;
      tally_and_finish;
   end
endmodule : rsp_serial_port_tb_top
`default_nettype wire
